// ===== hdl/fifo_write_port.sv
/*
 * Write side of a sequential flow-control FIFO: pin-level write port in
 * clocked or strobe timing, full / input-ready and almost-full flags,
 * serial offset load, memory address, bank and memory clock outputs, and
 * an Avalon-MM register slave with interrupt.
 * Assumes all pins are asynchronous to i_sys_clk and that the write
 * clock or strobe runs well below a quarter of the system clock rate.
 */
// The implementer's own choices: the Avalon-MM register port and the address map.
`timescale 1ns/100ps
`include "fifo_wr_map.svh"

// Contract
// - write timing select latched at master reset
// - accept 48, 24 or 12 bit words
// - standard mode: active-low full flag
// - fall-through mode: input ready indication
// - almost-full high while free exceeds offset
// - almost-full low when free at most offset
// - serial offset shift while load enable low
// - clocked mode: store word on enabled edge
// - strobe mode: store word on strobe edge
// - enable gates write clock, active low
// - chip select gates data inputs synchronously
// - drive 13-bit memory address bus
// - drive 2-bit bank select
// - drive memory clock and its complement
// - fall-through select latched at master reset
// - depth expand pin inverts standard full flag
module fifo_write_port #(
    parameter int DEPTH = 16,                     // stored words
    parameter int OFS_W = 16                      // width of each offset
) (
    input  wire logic        i_sys_clk,              // system clock, 20 MHz
    input  wire logic        i_sys_rst,              // synchronous reset, high
    input  wire logic [4:0]  i_avs_address,          // byte address
    input  wire logic        i_avs_read,             // read request
    input  wire logic        i_avs_write,            // write request
    input  wire logic [31:0] i_avs_writedata,        // write data
    input  wire logic [3:0]  i_avs_byteenable,       // byte lanes
    output logic      [31:0] o_avs_readdata,         // read data
    output logic             o_avs_waitrequest,      // slave stall
    input  wire logic        i_write_timing_select,  // strap: high clocked
    input  wire logic        i_fallthrough_mode,     // strap: high fall-through
    input  wire logic        i_depth_expand_invert,  // strap: invert full flag
    input  wire logic        i_wr_clk_strobe,        // write clock or strobe
    input  wire logic        i_wr_enable_n,          // write enable, low
    input  wire logic        i_input_chip_select_n,  // chip select, low
    input  wire logic [47:0] i_wr_data,              // write data bus
    input  wire logic        i_ser_clk,              // serial offset clock
    input  wire logic        i_ser_in,               // serial offset data
    input  wire logic        i_offset_load_enable_n, // serial load, low
    input  wire logic        i_scan_mode_pin,        // serial path when low
    output logic             o_full_or_input_ready,  // full or input ready
    output logic             o_almost_full_flag,     // almost-full flag
    output logic      [12:0] o_mem_addr,             // memory address bus
    output logic      [1:0]  o_mem_bank,             // bank select
    output logic             o_mem_clk_out,          // memory clock
    output logic             o_mem_clk_out_n,        // memory clock inverted
    output logic             o_irq                   // level interrupt
);

    localparam int AW = $clog2(DEPTH);
    localparam int LVL_W = 56;

    // pin synchronisation
    logic [1:0]       clk_lvl;
    logic [1:0]       clk_rise;
    logic [LVL_W-1:0] pin_lvl;

    edge_sync #(.W(2)) u_clk_sync (
        .i_sys_clk (i_sys_clk),
        .i_sys_rst (i_sys_rst),
        .i_async   ({i_ser_clk, i_wr_clk_strobe}),
        .o_level   (clk_lvl),
        .o_rise    (clk_rise)
    );

    // no reset here: the straps must reach the capture flops while reset is held
    edge_sync #(.W(LVL_W)) u_pin_sync (
        .i_sys_clk (i_sys_clk),
        .i_sys_rst (1'b0),
        .i_async   ({i_scan_mode_pin, i_write_timing_select, i_fallthrough_mode,
                     i_depth_expand_invert, i_wr_enable_n,
                     i_input_chip_select_n, i_ser_in,
                     i_offset_load_enable_n, i_wr_data}),
        .o_level   (pin_lvl),
        .o_rise    ()
    );

    wire                wr_edge  = clk_rise[0];
    wire                ser_edge = clk_rise[1];
    wire                s_scan   = pin_lvl[55];
    wire                s_timing = pin_lvl[54];
    wire                s_fallthrough_mode   = pin_lvl[53];
    wire                s_invert = pin_lvl[52];
    wire                s_en_n   = pin_lvl[51];
    wire                s_cs_n   = pin_lvl[50];
    wire                s_ser    = pin_lvl[49];
    wire                s_load_n = pin_lvl[48];
    fifo_wr_pkg::word_t s_data;
    assign s_data = pin_lvl[47:0];

    // mode straps, captured while master reset is held
    logic sync_mode;
    logic fallthrough_mode_mode;
    logic invert_mode;

    always_ff @(posedge i_sys_clk)
    begin
        if (i_sys_rst)
        begin
            sync_mode   <= s_timing;
            fallthrough_mode_mode   <= s_fallthrough_mode;
            invert_mode <= s_invert;
        end
    end

    // storage and occupancy
    fifo_wr_pkg::word_t mem [DEPTH];
    logic [AW-1:0]      wr_ptr;
    logic [AW-1:0]      rd_ptr;
    logic [AW:0]        count;
    logic [2*OFS_W-1:0] ofs_sr;
    fifo_wr_pkg::width_e width_sel;

    wire [AW:0]      free_cnt  = (AW+1)'(DEPTH) - count;
    wire             full_now  = (count == (AW+1)'(DEPTH));
    wire [OFS_W-1:0] full_ofs  = ofs_sr[OFS_W-1:0];
    wire             free_over = {{(OFS_W > AW+1 ? OFS_W-AW-1 : 0){1'b0}}, free_cnt}
                                 > full_ofs;

    // enable gates the clock only in clocked mode
    // chip select qualifies the data inputs
    wire wr_attempt = wr_edge & ~s_cs_n & (~sync_mode | ~s_en_n);
    wire do_write   = wr_attempt & ~full_now;
    wire overflow   = wr_attempt & full_now;

    // word masked to the configured input width
    fifo_wr_pkg::word_t wr_word;
    assign wr_word = (width_sel == fifo_wr_pkg::WIDTH_12) ? {36'h0_0000_0000, s_data[11:0]} :
                     (width_sel == fifo_wr_pkg::WIDTH_24) ? {24'h00_0000, s_data[23:0]} :
                     s_data;

    // register decode
    wire bus_req   = i_avs_read | i_avs_write;
    wire bus_done  = bus_req & ~o_avs_waitrequest;
    wire wr_strobe = i_avs_write & bus_done & i_avs_byteenable[0];
    wire rd_pop    = i_avs_read & bus_done & (i_avs_address == `FWR_ADDR_DATA_HI)
                     & (count != '0);
    wire sel_ctrl  = (i_avs_address == `FWR_ADDR_CTRL);
    wire sel_stat  = (i_avs_address == `FWR_ADDR_IRQ_STAT);
    wire sel_mask  = (i_avs_address == `FWR_ADDR_IRQ_MASK);

    always_ff @(posedge i_sys_clk)
    begin
        if (do_write)
        begin
            mem[wr_ptr] <= wr_word;
        end
    end

    // pointers and occupancy; a pop and a write may coincide
    always_ff @(posedge i_sys_clk)
    begin
        if (i_sys_rst)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end
        else
        begin
            wr_ptr <= wr_ptr + AW'(do_write);
            rd_ptr <= rd_ptr + AW'(rd_pop);
            count  <= count + (AW+1)'(do_write) - (AW+1)'(rd_pop);
        end
    end

    // serial offset shift, empty offset upper, full offset lower
    always_ff @(posedge i_sys_clk)
    begin
        if (i_sys_rst)
        begin
            ofs_sr <= {`FWR_OFS_RST, `FWR_OFS_RST};
        end
        else if (ser_edge && !s_load_n && !s_scan)
        begin
            ofs_sr <= {ofs_sr[2*OFS_W-2:0], s_ser};
        end
    end

    // flags follow write clock edges in clocked mode
    wire flag_upd = sync_mode ? wr_edge : 1'b1;

    // full flag high while space remains unless inverted; in fall-through mode input ready, low while space remains
    wire next_ffir = fallthrough_mode_mode ? full_now : (~full_now ^ invert_mode);

    // flag outputs, straight from flops
    always_ff @(posedge i_sys_clk)
    begin
        if (i_sys_rst)
        begin
            o_full_or_input_ready <= 1'b1;
            o_almost_full_flag    <= 1'b1;
        end
        else if (flag_upd)
        begin
            o_full_or_input_ready <= next_ffir;
            // low when free at most offset
            o_almost_full_flag    <= free_over;
        end
    end

    // linear write address split over bank and address
    // bank from the top address bits
    // row and column multiplexing belongs to the command sequencer
    always_ff @(posedge i_sys_clk)
    begin
        if (i_sys_rst)
        begin
            o_mem_addr <= '0;
            o_mem_bank <= '0;
        end
        else if (do_write)
        begin
            {o_mem_bank, o_mem_addr} <= {o_mem_bank, o_mem_addr} + 15'h0001;
        end
    end

    // memory clock divider, complementary pair from two flops
    logic [7:0] clk_div;
    wire        clk_tick = (clk_div == 8'(`FWR_MEMCLK_HALF_CYC - 1));

    always_ff @(posedge i_sys_clk)
    begin
        if (i_sys_rst)
        begin
            clk_div         <= '0;
            o_mem_clk_out   <= 1'b0;
            o_mem_clk_out_n <= 1'b1;
        end
        else
        begin
            clk_div <= clk_tick ? 8'h00 : clk_div + 8'h01;
            if (clk_tick)
            begin
                o_mem_clk_out   <= ~o_mem_clk_out;
                o_mem_clk_out_n <= o_mem_clk_out;
            end
        end
    end

    // interrupt events; set wins over a same-cycle clear
    logic [`FWR_IRQ_BITS-1:0] irq_stat;
    logic [`FWR_IRQ_BITS-1:0] irq_mask;
    logic                     full_prev;
    logic                     almost_prev;
    wire  [`FWR_IRQ_BITS-1:0] irq_evt;
    wire  [`FWR_IRQ_BITS-1:0] irq_clr;

    assign irq_evt[`FWR_IRQ_FULL]     = full_now & ~full_prev;
    assign irq_evt[`FWR_IRQ_ALMOST]   = ~free_over & almost_prev;
    assign irq_evt[`FWR_IRQ_OVERFLOW] = overflow;
    assign irq_clr = (wr_strobe && sel_stat) ? i_avs_writedata[`FWR_IRQ_BITS-1:0] : '0;

    always_ff @(posedge i_sys_clk)
    begin
        if (i_sys_rst)
        begin
            irq_stat    <= '0;
            irq_mask    <= '0;
            full_prev   <= 1'b0;
            almost_prev <= 1'b1;
            o_irq       <= 1'b0;
            width_sel   <= fifo_wr_pkg::width_e'(`FWR_WIDTH_RST);
        end
        else
        begin
            irq_stat    <= (irq_stat & ~irq_clr) | irq_evt;
            full_prev   <= full_now;
            almost_prev <= free_over;
            o_irq       <= |(((irq_stat & ~irq_clr) | irq_evt) & irq_mask);
            if (wr_strobe && sel_mask)
            begin
                irq_mask <= i_avs_writedata[`FWR_IRQ_BITS-1:0];
            end
            if (wr_strobe && sel_ctrl)
            begin
                width_sel <= fifo_wr_pkg::width_e'(i_avs_writedata[1:0]);
            end
        end
    end

    // read data selection; unmapped reads return zero
    fifo_wr_pkg::word_t head;
    wire [31:0]         status_word;
    logic [31:0]        rd_mux;

    assign head = mem[rd_ptr];
    assign status_word = {{(24-AW-1){1'b0}}, count, 3'b000, invert_mode, fallthrough_mode_mode,
                          sync_mode, o_almost_full_flag, full_now};

    always_comb
    begin
        case (i_avs_address)
            `FWR_ADDR_CTRL:     rd_mux = {30'h0000_0000, width_sel};
            `FWR_ADDR_STATUS:   rd_mux = status_word;
            `FWR_ADDR_IRQ_STAT: rd_mux = {29'h0000_0000, irq_stat};
            `FWR_ADDR_IRQ_MASK: rd_mux = {29'h0000_0000, irq_mask};
            `FWR_ADDR_DATA_LO:  rd_mux = head[31:0];
            `FWR_ADDR_DATA_HI:  rd_mux = {16'h0000, head[47:32]};
            `FWR_ADDR_OFFSET:   rd_mux = ofs_sr;
            default:            rd_mux = 32'h0000_0000;
        endcase
    end

    // one wait cycle per access keeps the read mux off the critical path
    always_ff @(posedge i_sys_clk)
    begin
        if (i_sys_rst)
        begin
            o_avs_waitrequest <= 1'b1;
            o_avs_readdata    <= '0;
        end
        else
        begin
            o_avs_waitrequest <= ~(bus_req & o_avs_waitrequest);
            if (i_avs_read && o_avs_waitrequest)
            begin
                o_avs_readdata <= rd_mux;
            end
        end
    end

    // checks
    sequence s_wr_taken;
        do_write;
    endsequence

    sequence s_ser_shift;
        ser_edge && !s_load_n && !s_scan;
    endsequence

    chk_strap_latch: assert property (@(posedge i_sys_clk)
        $fell(i_sys_rst) |-> sync_mode == $past(s_timing) && fallthrough_mode_mode == $past(s_fallthrough_mode))
        else $error("strap not caught at reset");

    chk_enable_gate: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
        sync_mode && s_en_n |-> !do_write)
        else $error("write taken with enable high");

    chk_select_gate: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
        s_cs_n |-> !do_write)
        else $error("write taken without chip select");

    chk_strobe_write: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
        !sync_mode && wr_edge && !s_cs_n && !full_now |-> s_wr_taken)
        else $error("strobe edge not stored");

    chk_ptr_advance: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
        s_wr_taken |=> wr_ptr == $past(wr_ptr) + AW'(1))
        else $error("write pointer did not advance");

    chk_word_width: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
        (s_wr_taken and (width_sel == fifo_wr_pkg::WIDTH_12)) |-> wr_word[47:12] == '0)
        else $error("narrow word not masked");

    chk_full_flag: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
        flag_upd && !fallthrough_mode_mode |=> o_full_or_input_ready == ($past(~full_now) ^ invert_mode))
        else $error("full flag wrong in standard mode");

    chk_ready_flag: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
        flag_upd && fallthrough_mode_mode |=> o_full_or_input_ready == $past(full_now))
        else $error("input ready wrong in fall-through mode");

    chk_almost_full: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
        flag_upd |=> o_almost_full_flag == $past(free_over))
        else $error("almost-full flag does not match free count");

    chk_offset_shift: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
        s_ser_shift |=> ofs_sr[0] == $past(s_ser) && ofs_sr[1] == $past(ofs_sr[0]))
        else $error("serial offset not shifted");

    chk_addr_step: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
        s_wr_taken |=> {o_mem_bank, o_mem_addr} == $past({o_mem_bank, o_mem_addr}) + 15'h0001)
        else $error("memory address did not step");

    chk_clk_pair: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
        o_mem_clk_out != o_mem_clk_out_n)
        else $error("memory clock pair not complementary");

endmodule

// ===== hdl/fifo_wr_map.svh
/*
 * Register offsets, field positions, reset values and timing counts for the
 * FIFO write port. Assumes a 32-bit Avalon-MM slave with byte addresses.
 */
`ifndef FIFO_WR_MAP_SVH
`define FIFO_WR_MAP_SVH

// register byte offsets
`define FWR_ADDR_CTRL      5'h00
`define FWR_ADDR_STATUS    5'h04
`define FWR_ADDR_IRQ_STAT  5'h08
`define FWR_ADDR_IRQ_MASK  5'h0C
`define FWR_ADDR_DATA_LO   5'h10
`define FWR_ADDR_DATA_HI   5'h14
`define FWR_ADDR_OFFSET    5'h18

// interrupt status / mask bit positions
`define FWR_IRQ_FULL       0
`define FWR_IRQ_ALMOST     1
`define FWR_IRQ_OVERFLOW   2
`define FWR_IRQ_BITS       3

// status register bit positions
`define FWR_ST_FULL        0
`define FWR_ST_ALMOST      1
`define FWR_ST_SYNC        2
`define FWR_ST_FALLTHROUGH_MODE        3
`define FWR_ST_INVERT      4
`define FWR_ST_COUNT_LSB   8

// reset values
`define FWR_OFS_RST        16'h0004
`define FWR_WIDTH_RST      2'b00

// memory clock: time of one half period in ns, at a 50 ns system clock
`define FWR_SYS_CLK_NS     50
`define FWR_MEMCLK_HALF_NS 100
`define FWR_MEMCLK_HALF_CYC (`FWR_MEMCLK_HALF_NS / `FWR_SYS_CLK_NS)

`endif

// ===== hdl/fifo_wr_pkg.sv
/*
 * Types shared by the FIFO write port files.
 * Assumes nothing of its surroundings.
 */
package fifo_wr_pkg;

    // input port width selection, gray ordered
    typedef enum logic [1:0]
    {
        WIDTH_48 = 2'b00,
        WIDTH_24 = 2'b01,
        WIDTH_12 = 2'b11
    } width_e;

    typedef logic [47:0] word_t;

endpackage

// ===== hdl/edge_sync.sv
/*
 * Two-flop synchroniser with rising edge detect, one lane per bit.
 * Assumes inputs come from outside the i_sys_clk domain.
 */
`timescale 1ns/100ps

module edge_sync #(
    parameter int W = 1
) (
    input  wire logic         i_sys_clk,  // system clock
    input  wire logic         i_sys_rst,  // synchronous reset, high
    input  wire logic [W-1:0] i_async,    // raw pin levels
    output logic      [W-1:0] o_level,    // synchronised level
    output logic      [W-1:0] o_rise      // one-cycle pulse per rising edge
);

    logic [W-1:0] meta;
    logic [W-1:0] stage;
    logic [W-1:0] prev;

    // first flop feeds only the second; edges seen from stage two onward
    always_ff @(posedge i_sys_clk)
    begin
        if (i_sys_rst)
        begin
            meta  <= '0;
            stage <= '0;
            prev  <= '0;
        end
        else
        begin
            meta  <= i_async;
            stage <= meta;
            prev  <= stage;
        end
    end

    assign o_level = stage;
    assign o_rise  = stage & ~prev;

endmodule

// ===== dv/wr_source.sv
/*
 * Upstream write logic model: free-running write clock or write strobe,
 * enable, chip select and data for the write port.
 * Assumes the bench sets i_clocked to match the timing strap at reset.
 */
`timescale 1ns/100ps

module wr_source (
    input  wire logic        i_clocked,             // high: clocked timing
    output logic             o_wr_clk_strobe,       // write clock or strobe
    output logic             o_wr_enable_n,         // write enable, low
    output logic             o_input_chip_select_n, // chip select, low
    output logic      [47:0] o_wr_data              // write data
);
    logic en_n;
    event tick;

    // strobe timing holds the enable low
    assign o_wr_enable_n = i_clocked ? en_n : 1'b0;

    // 400 ns period; the strobe stands still unless a word is sent
    initial
    begin
        o_wr_clk_strobe = 1'b0;
        en_n = 1'b1;
        o_input_chip_select_n = 1'b1;
        o_wr_data = '0;
        forever
        begin
            #200;
            -> tick;
            if (i_clocked)
                o_wr_clk_strobe = ~o_wr_clk_strobe;
        end
    end

    // one word per call; released data shows the inverse of the last word
    task put(input logic [47:0] w, input logic csn);
        if (i_clocked)
        begin
            @(negedge o_wr_clk_strobe);
            en_n = 1'b0;
            o_input_chip_select_n = csn;
            o_wr_data = w;
            // enable and data held across the rising edge
            @(negedge o_wr_clk_strobe);
        end
        else
        begin
            @(tick);
            o_wr_clk_strobe = 1'b0;
            o_input_chip_select_n = csn;
            o_wr_data = w;
            @(tick);
            o_wr_clk_strobe = 1'b1;
            @(tick);
            o_wr_clk_strobe = 1'b0;
        end
        en_n = 1'b1;
        o_input_chip_select_n = 1'b1;
        o_wr_data = ~w;
    endtask
endmodule

// ===== dv/fifo_write_port_and_memory_addr_bench.sv
/*
 * Self-checking bench for the FIFO write port: fill, overflow, drain,
 * widths, chip select, interrupt, serial offset and strap modes.
 * Assumes the register map header and the upstream write model.
 */
`timescale 1ns/100ps
`include "fifo_wr_map.svh"

module fifo_write_port_and_memory_addr_bench;
    logic        clk, rst, rd, wr, sel, ft, inv, sclk, sin, ld_n;
    logic        wclk, wen_n, cs_n, fir, af, mck, mckn, irq, wq, scan;
    logic [4:0]  adr;
    logic [3:0]  be;
    logic [31:0] wd, rdq, v, lo, hi;
    logic [12:0] maddr;
    logic [1:0]  mbank;
    logic [47:0] wdat, w, q[$];
    logic        h[8];
    int          err_count, n_tests, seed, k, i;
    fifo_wr_pkg::width_e wt[3] = '{fifo_wr_pkg::WIDTH_48, fifo_wr_pkg::WIDTH_24,
                                   fifo_wr_pkg::WIDTH_12};
    logic [47:0] mk[3] = '{48'hFFFF_FFFF_FFFF, 48'h0000_00FF_FFFF, 48'h0000_0000_0FFF};

    fifo_write_port i_dut (.i_sys_clk(clk), .i_sys_rst(rst), .i_avs_address(adr),
        .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(be),
        .o_avs_readdata(rdq), .o_avs_waitrequest(wq), .i_write_timing_select(sel),
        .i_fallthrough_mode(ft), .i_depth_expand_invert(inv), .i_wr_clk_strobe(wclk),
        .i_wr_enable_n(wen_n), .i_input_chip_select_n(cs_n), .i_wr_data(wdat),
        .i_ser_clk(sclk), .i_ser_in(sin), .i_offset_load_enable_n(ld_n),
        .i_scan_mode_pin(scan), .o_full_or_input_ready(fir), .o_almost_full_flag(af),
        .o_mem_addr(maddr), .o_mem_bank(mbank), .o_mem_clk_out(mck),
        .o_mem_clk_out_n(mckn), .o_irq(irq));

    wr_source i_src (.i_clocked(sel), .o_wr_clk_strobe(wclk), .o_wr_enable_n(wen_n),
        .o_input_chip_select_n(cs_n), .o_wr_data(wdat));

    // 20 MHz system clock
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // overall limit; a hang counts as a mismatch
    initial
    begin
        repeat (100000) @(posedge clk);
        chk(1'b0, 1'b1, "run timeout");
        end_sim();
    end

    task end_sim();
        if (err_count == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task chk(input logic [47:0] g, input logic [47:0] e, input string m);
        n_tests++;
        if (g !== e)
        begin
            err_count++;
            $display("MISMATCH %0t %s", $time, m);
        end
    endtask

    // one bus cycle, held until waitrequest is sampled low
    task bus(input logic w1, input logic [4:0] a, input logic [31:0] d,
             output logic [31:0] r);
        int n;
        n = 0;
        @(posedge clk);
        adr <= a;
        wd <= d;
        wr <= w1;
        rd <= !w1;
        // look at each falling edge, where wq and rdq are settled
        do
        begin
            @(negedge clk);
            n++;
        end
        while (wq !== 1'b0 && n < 64);
        r = rdq;
        @(posedge clk);
        wr <= 1'b0;
        rd <= 1'b0;
        if (n >= 64)
        begin
            chk(1'b0, 1'b1, "bus timeout");
            end_sim();
        end
    endtask

    // one offset bit per 400 ns serial clock, msb first
    task shift(input logic [31:0] x);
        @(posedge clk);
        ld_n <= 1'b0;
        for (i = 31; i >= 0; i--)
        begin
            sin <= x[i];
            repeat (4) @(posedge clk);
            sclk <= 1'b1;
            repeat (4) @(posedge clk);
            sclk <= 1'b0;
        end
        ld_n <= 1'b1;
    endtask

    // covers the next write clock edge plus the pin synchroniser
    task settle();
        repeat (16) @(posedge clk);
    endtask

    task reset(input logic s, input logic f, input logic x);
        sel <= s;
        ft <= f;
        inv <= x;
        rst <= 1'b1;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        settle();
    endtask

    task pop(input logic [47:0] e);
        bus(0, `FWR_ADDR_DATA_LO, 0, lo);
        bus(0, `FWR_ADDR_DATA_HI, 0, hi);
        chk({hi[15:0], lo}, e, "popped word");
    endtask

    // main sequence
    initial
    begin
        seed = 32'hf545;
        err_count = 0;
        n_tests = 0;
        {rd, wr, sclk, sin, scan} <= '0;
        {adr, wd} <= '0;
        be <= 4'hf;
        ld_n <= 1'b1;
        reset(1, 0, 0);
        bus(0, `FWR_ADDR_STATUS, 0, v);
        chk(v[4:2], 3'b001, "strap bits");
        bus(0, `FWR_ADDR_OFFSET, 0, v);
        chk(v, 32'h0004_0004, "offset reset");
        bus(0, 5'h1C, 0, v);
        chk(v, 0, "unmapped read");
        // fill past full; the last word overflows
        for (k = 1; k <= 17; k++)
        begin
            w = {16'($random(seed)), 32'($random(seed))};
            if (k <= 16)
                q.push_back(w);
            i_src.put(w, 1'b0);
            settle();
            chk(af, (k < 12), "almost full");
            chk(fir, (k < 16), "full flag");
        end
        chk({mbank, maddr}, 15'h0010, "memory address");
        bus(0, `FWR_ADDR_IRQ_STAT, 0, v);
        chk(v[2:0], 3'b111, "irq status");
        chk(irq, 0, "irq masked");
        bus(1, `FWR_ADDR_IRQ_MASK, 32'h0000_0004, v);
        repeat (2) @(posedge clk);
        chk(irq, 1, "irq raised");
        bus(1, `FWR_ADDR_IRQ_STAT, 32'h0000_0007, v);
        repeat (2) @(posedge clk);
        chk(irq, 0, "irq cleared");
        while (q.size() > 0)
            pop(q.pop_front());
        settle();
        chk(fir, 1, "full released");
        chk(af, 1, "almost full released");
        i_src.put(48'h1234_5678_9ABC, 1'b1);
        settle();
        bus(0, `FWR_ADDR_STATUS, 0, v);
        chk(v[12:8], 0, "deselected write");
        for (i = 0; i < 3; i++)
        begin
            bus(1, `FWR_ADDR_CTRL, {30'h0, wt[i]}, v);
            w = {16'($random(seed)), 32'($random(seed))};
            i_src.put(w, 1'b0);
            settle();
            pop(w & mk[i]);
        end
        be <= 4'h0;
        bus(1, `FWR_ADDR_CTRL, 0, v);
        be <= 4'hf;
        bus(0, `FWR_ADDR_CTRL, 0, v);
        chk(v[1:0], 2'b11, "lane 0 off");
        for (i = 0; i < 8; i++)
        begin
            @(negedge clk);
            h[i] = mck;
            chk(mckn, !mck, "clock pair");
        end
        for (i = 2; i < 8; i++)
            chk(h[i], !h[i-2], "clock half period");
        v = {16'($random(seed)), 16'h0010};
        shift(v);
        bus(0, `FWR_ADDR_OFFSET, 0, lo);
        chk(lo, v, "serial offset");
        scan <= 1'b1;
        shift(~v);
        bus(0, `FWR_ADDR_OFFSET, 0, lo);
        chk(lo, v, "scan mode holds offset");
        scan <= 1'b0;
        settle();
        chk(af, 0, "free equals offset");
        reset(0, 0, 1);
        bus(0, `FWR_ADDR_STATUS, 0, v);
        chk(v[4:2], 3'b100, "strobe straps");
        chk(fir, 0, "inverted flag");
        w = {16'($random(seed)), 32'($random(seed))};
        i_src.put(w, 1'b0);
        settle();
        pop(w);
        reset(1, 1, 0);
        bus(0, `FWR_ADDR_STATUS, 0, v);
        chk(v[4:2], 3'b011, "fall-through straps");
        chk(fir, 0, "input ready");
        end_sim();
    end
endmodule
